// File: design/dts_defs.svh
// Purpose: Named offsets, field positions, codes and fill values of the
//          track and sector read command engine.
// Assumes: Included by bare name from each design file that needs it.
// Notes:   Definitions only.
`ifndef DTS_DEFS_SVH
`define DTS_DEFS_SVH
// Register offsets on the host port
`define DTS_A_MODE    4'h0
`define DTS_A_BUFLO   4'h1
`define DTS_A_BUFHI   4'h2
`define DTS_A_CYL     4'h3
`define DTS_A_HEAD    4'h4
`define DTS_A_SECT    4'h5
`define DTS_A_COUNT   4'h6
`define DTS_A_RETRY   4'h7
`define DTS_A_CMD     4'h8
`define DTS_A_STATUS  4'h9
`define DTS_A_DATA    4'hA
// Command opcodes (upper bits of the command byte)
`define DTS_OP_TRACK  7'h2D
`define DTS_OP_PHYS   7'h2C
`define DTS_OP_LOG    6'h17
`define DTS_OP_FMT    3'h3
`define DTS_CB_OPT0   0
`define DTS_CB_BYPASS 1
// Termination codes
`define DTS_TC_OK     2'h0
`define DTS_TC_ID     2'h1
`define DTS_TC_BAD    2'h2
`define DTS_TC_DATA   2'h3
// Status byte fields
`define DTS_ST_BUSY   7
`define DTS_ST_BAD    6
`define DTS_ST_DONE   5
// ID field layout
`define DTS_ID_BADBIT 7
`define DTS_ID_LAST   2'h3

// Format fill bytes and gap length
`define DTS_FILL_DATA 8'hE5
`define DTS_FILL_GAP  8'h4E
`define DTS_FMT_GAP   10'h010

`endif

// File: design/dts_pkg.sv
// Purpose: Types shared by the track and sector read command engine.
// Assumes: Compiled before every design module.
// Notes:   Numbers live in dts_defs.svh, types live here.
package dts_pkg;

  // Termination code carried on the status port
  typedef logic [1:0] dts_term_t;

  // Command engine states
  typedef enum logic [3:0] {
    S_IDLE,
    S_FMT_WAIT,
    S_FMT_GAP1,
    S_FMT_ID,
    S_FMT_GAP2,
    S_FMT_DATA,
    S_TRK_WAIT,
    S_TRK_RUN,
    S_SEARCH,
    S_ID,
    S_DATA_WAIT,
    S_DATA,
    S_FINISH
  } dts_state_t;

endpackage

// File: design/dts_index_sync.sv
// Purpose: Brings the drive index pin into the clock domain and marks
//          its leading edge.
// Assumes: Index pulses last several clock cycles.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
module dts_index_sync (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  // Pin and results
  input  wire logic pin_in,
  output logic      rise_out
);

  logic meta;
  logic stable;
  logic last;

  // Two-stage synchroniser plus one delay stage for the edge
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta   <= 1'b0;
      stable <= 1'b0;
      last   <= 1'b0;
    end else begin
      meta   <= pin_in;
      stable <= meta;
      last   <= stable;
    end
  end

  // Leading edge, one cycle long
  assign rise_out = stable & ~last;

endmodule // dts_index_sync

// File: design/dts_buffer_mem.sv
// Purpose: Disk data buffer, one write port and one registered read port.
// Assumes: Write and read addresses come from the same clock domain.
// Notes:   Read data appear one cycle after the read address.
`timescale 1ns/1ps
module dts_buffer_mem #(
  parameter int AW = 14,
  parameter int DW = 8
) (
  // Clock and reset
  input  wire logic          clk_in,
  input  wire logic          arst_n_in,
  // Write port
  input  wire logic          we_in,
  input  wire logic [AW-1:0] waddr_in,
  input  wire logic [DW-1:0] wdata_in,
  // Read port
  input  wire logic [AW-1:0] raddr_in,
  output logic      [DW-1:0] rdata_out
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Array has no reset, it is plain storage
  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
  end

  // Registered read keeps the output off the array decode path
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_out <= '0;
    end else begin
      rdata_out <= mem[raddr_in];
    end
  end

endmodule // dts_buffer_mem

// File: design/dts_cmd_engine.sv
// Purpose: Command engine for track format fill, whole-track read,
//          physical sector read and logical sector read.
// Assumes: Read channel and write serialiser run on clk_in; index pin
//          is asynchronous. Host is idle-polled through the status byte.
// Notes:   Host register writes are ignored while a command runs.
`timescale 1ns/1ps
`include "dts_defs.svh"

module dts_cmd_engine #(
  parameter int AW           = 14,
  parameter int SECTOR_BYTES = 512
) (
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              arst_n_in,
  // Host register port
  input  wire logic [3:0]        addr_in,
  input  wire logic [7:0]        wdata_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  output logic      [7:0]        rd_data_out,
  // Drive read channel
  input  wire logic              index_pin_in,
  input  wire logic              rd_field_start_in,
  input  wire logic              rd_field_is_data_in,
  input  wire logic              rd_byte_strobe_in,
  input  wire logic [7:0]        rd_byte_in,
  input  wire logic              rd_field_end_in,
  input  wire logic              rd_crc_ok_in,
  output logic                   read_gate_out,
  // Drive write serialiser
  input  wire logic              wr_byte_req_in,
  output logic      [7:0]        wr_byte_out,
  output logic                   write_gate_out,
  // Status port
  output dts_pkg::dts_term_t     termination_code_out,
  output logic                   bad_sector_flag_out,
  output logic                   busy_out,
  output logic                   cmd_done_out
);
  import dts_pkg::*;

  // Elaboration checks
  if (AW < 8 || AW > 16) begin : g_bad_aw
    $error("AW must lie between 8 and 16");
  end
  if (SECTOR_BYTES < 1 || SECTOR_BYTES > 1023) begin : g_bad_sb
    $error("SECTOR_BYTES must lie between 1 and 1023");
  end

  localparam logic [9:0] SB_LAST = 10'(SECTOR_BYTES - 1);

  // Registers
  logic [7:0]    drive_mode_reg;
  logic [15:0]   buffer_address_regs;
  logic [7:0]    desired_cylinder_reg;
  logic [7:0]    desired_head_reg;
  logic [7:0]    desired_sector_reg;
  logic [7:0]    sector_count_reg;
  logic [7:0]    retry_count_reg;
  logic          done_sticky;
  logic [AW-1:0] host_ptr;

  // Engine state
  dts_state_t    state;
  logic [AW-1:0] eng_addr;
  logic [AW-1:0] sec_base;
  logic [9:0]    byte_cnt;
  logic [7:0]    retry_left;
  logic [7:0]    id_cyl;
  logic [7:0]    id_hd;
  logic [7:0]    id_sec;
  logic          idx_seen;
  logic          first_sec;
  logic          trk_cap;
  logic          op_track;
  logic          op_fmt;
  logic          op_log;
  logic          opt_data;
  logic          opt_bypass;

  // Host decode
  wire idle       = (state == S_IDLE);
  wire hw         = wr_in & idle;
  wire w_mode     = hw & (addr_in == `DTS_A_MODE);
  wire w_buflo    = hw & (addr_in == `DTS_A_BUFLO);
  wire w_bufhi    = hw & (addr_in == `DTS_A_BUFHI);
  wire w_cyl      = hw & (addr_in == `DTS_A_CYL);
  wire w_head     = hw & (addr_in == `DTS_A_HEAD);
  wire w_sect     = hw & (addr_in == `DTS_A_SECT);
  wire w_count    = hw & (addr_in == `DTS_A_COUNT);
  wire w_retry    = hw & (addr_in == `DTS_A_RETRY);
  wire w_cmd      = hw & (addr_in == `DTS_A_CMD);
  wire w_data     = hw & (addr_in == `DTS_A_DATA);
  wire r_data     = rd_in & idle & (addr_in == `DTS_A_DATA);

  // Command decode
  wire cmd_track  = wdata_in[7:1] == `DTS_OP_TRACK;
  wire cmd_phys   = wdata_in[7:1] == `DTS_OP_PHYS;
  wire cmd_log    = wdata_in[7:2] == `DTS_OP_LOG;
  wire cmd_fmt    = wdata_in[7:5] == `DTS_OP_FMT;
  wire cmd_sector = cmd_phys | cmd_log;

  // Index edge from the synchroniser
  wire idx_rise;

  // ID verify terms
  wire id_match   = (id_cyl == desired_cylinder_reg) &&
                    (id_hd[6:0] == desired_head_reg[6:0]) &&
                    (id_sec == desired_sector_reg);
  wire id_bad     = id_hd[`DTS_ID_BADBIT];
  wire need_match = first_sec | op_log;
  wire can_retry  = op_log & (retry_left != 8'h00);
  wire count_last = (sector_count_reg == 8'h01);

  // Buffer port sharing: engine while busy, host while idle
  wire trk_we     = (state == S_TRK_RUN) & trk_cap & rd_byte_strobe_in;
  wire dat_we     = (state == S_DATA) & opt_data & rd_byte_strobe_in;
  wire mem_we     = trk_we | dat_we | w_data;
  wire [AW-1:0] mem_addr = idle ? host_ptr : eng_addr;
  wire [7:0]    mem_wdat = idle ? wdata_in : rd_byte_in;
  wire [7:0]    mem_q;

  // Status byte and read mux
  wire [7:0] status_byte = {~idle, bad_sector_flag_out, done_sticky,
                            3'h0, termination_code_out};
  wire [7:0] rd_sel =
    (addr_in == `DTS_A_MODE)   ? drive_mode_reg :
    (addr_in == `DTS_A_BUFLO)  ? buffer_address_regs[7:0] :
    (addr_in == `DTS_A_BUFHI)  ? buffer_address_regs[15:8] :
    (addr_in == `DTS_A_CYL)    ? desired_cylinder_reg :
    (addr_in == `DTS_A_HEAD)   ? desired_head_reg :
    (addr_in == `DTS_A_SECT)   ? desired_sector_reg :
    (addr_in == `DTS_A_COUNT)  ? sector_count_reg :
    (addr_in == `DTS_A_RETRY)  ? retry_count_reg :
    (addr_in == `DTS_A_STATUS) ? status_byte :
    (addr_in == `DTS_A_DATA)   ? mem_q : 8'h00;

  dts_index_sync u_idx (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .pin_in    (index_pin_in),
    .rise_out  (idx_rise)
  );

  dts_buffer_mem #(.AW(AW), .DW(8)) u_mem (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .we_in     (mem_we),
    .waddr_in  (mem_addr),
    .wdata_in  (mem_wdat),
    .raddr_in  (mem_addr),
    .rdata_out (mem_q)
  );

  // Host-only registers, read data and the buffer data pointer
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      drive_mode_reg       <= 8'h00;
      desired_cylinder_reg <= 8'h00;
      desired_head_reg     <= 8'h00;
      retry_count_reg      <= 8'h00;
      host_ptr             <= '0;
      rd_data_out          <= 8'h00;
    end else begin
      if (w_mode)  drive_mode_reg       <= wdata_in;
      if (w_cyl)   desired_cylinder_reg <= wdata_in;
      if (w_head)  desired_head_reg     <= wdata_in;
      if (w_retry) retry_count_reg      <= wdata_in;
      if (w_buflo | w_bufhi) begin
        host_ptr <= w_buflo ?
          AW'({buffer_address_regs[15:8], wdata_in}) :
          AW'({wdata_in, buffer_address_regs[7:0]});
      end else if (w_data | r_data) begin
        host_ptr <= host_ptr + 1'b1;   // Auto-increment per data access
      end
      rd_data_out <= rd_in ? rd_sel : 8'h00;
    end
  end

  // Command engine; shared registers live here to keep one driver
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state                <= S_IDLE;
      buffer_address_regs  <= 16'h0000;
      desired_sector_reg   <= 8'h00;
      sector_count_reg     <= 8'h00;
      eng_addr             <= '0;
      sec_base             <= '0;
      byte_cnt             <= 10'h000;
      retry_left           <= 8'h00;
      id_cyl               <= 8'h00;
      id_hd                <= 8'h00;
      id_sec               <= 8'h00;
      idx_seen             <= 1'b0;
      first_sec            <= 1'b0;
      trk_cap              <= 1'b0;
      op_track             <= 1'b0;
      op_fmt               <= 1'b0;
      op_log               <= 1'b0;
      opt_data             <= 1'b0;
      opt_bypass           <= 1'b0;
      wr_byte_out          <= `DTS_FILL_GAP;
      write_gate_out       <= 1'b0;
      read_gate_out        <= 1'b0;
      termination_code_out <= `DTS_TC_OK;
      bad_sector_flag_out  <= 1'b0;
      busy_out             <= 1'b0;
      cmd_done_out         <= 1'b0;
      done_sticky          <= 1'b0;
    end else begin
      cmd_done_out <= 1'b0;
      case (state)
        S_IDLE: begin
          if (w_buflo) buffer_address_regs[7:0]  <= wdata_in;
          if (w_bufhi) buffer_address_regs[15:8] <= wdata_in;
          if (w_sect)  desired_sector_reg        <= wdata_in;
          if (w_count) sector_count_reg          <= wdata_in;
          if (w_cmd & (cmd_track | cmd_sector | cmd_fmt)) begin
            eng_addr            <= buffer_address_regs[AW-1:0];
            sec_base            <= buffer_address_regs[AW-1:0];
            op_track            <= cmd_track;
            op_fmt              <= cmd_fmt;
            op_log              <= cmd_log;
            opt_data            <= wdata_in[`DTS_CB_OPT0];
            opt_bypass          <= cmd_log & wdata_in[`DTS_CB_BYPASS];
            retry_left          <= ~retry_count_reg;
            first_sec           <= 1'b1;
            idx_seen            <= 1'b0;
            trk_cap             <= 1'b0;
            busy_out            <= 1'b1;
            done_sticky         <= 1'b0;
            bad_sector_flag_out <= 1'b0;
            termination_code_out <= `DTS_TC_OK;
            // Track read and format skip ID search and verify
            state <= cmd_fmt ? S_FMT_WAIT :
                     cmd_track ? S_TRK_WAIT : S_SEARCH;
            read_gate_out <= cmd_sector;
          end
        end
        // Format: gap, ID from buffer table, gap, data, until index
        S_FMT_WAIT: begin
          if (idx_rise) begin
            state          <= S_FMT_GAP1;
            byte_cnt       <= 10'h000;
            write_gate_out <= 1'b1;
          end
        end
        S_FMT_GAP1, S_FMT_GAP2, S_FMT_ID, S_FMT_DATA: begin
          if (idx_rise) begin
            write_gate_out <= 1'b0;
            state          <= S_FINISH;
          end else if (wr_byte_req_in) begin
            byte_cnt <= byte_cnt + 1'b1;
            if (state == S_FMT_ID) begin
              wr_byte_out <= mem_q;
              eng_addr    <= eng_addr + 1'b1;
              if (byte_cnt[1:0] == `DTS_ID_LAST) begin
                state    <= S_FMT_GAP2;
                byte_cnt <= 10'h000;
              end
            end else if (state == S_FMT_DATA) begin
              wr_byte_out <= `DTS_FILL_DATA;
              if (byte_cnt == SB_LAST) begin
                state    <= S_FMT_GAP1;
                byte_cnt <= 10'h000;
              end
            end else begin
              wr_byte_out <= `DTS_FILL_GAP;
              if (byte_cnt == `DTS_FMT_GAP - 10'h001) begin
                state    <= (state == S_FMT_GAP1) ? S_FMT_ID : S_FMT_DATA;
                byte_cnt <= 10'h000;
              end
            end
          end
        end
        // Whole-track read from index to index
        S_TRK_WAIT: begin
          if (idx_rise) begin
            state         <= S_TRK_RUN;
            read_gate_out <= 1'b1;
          end
        end
        S_TRK_RUN: begin
          if (idx_rise) begin
            read_gate_out <= 1'b0;
            state         <= S_FINISH;
          end else begin
            if (rd_field_start_in) begin
              trk_cap <= ~rd_field_is_data_in | opt_data;
            end else if (rd_field_end_in) begin
              trk_cap <= 1'b0;   // CRC result ignored here
            end
            if (trk_we) eng_addr <= eng_addr + 1'b1;
          end
        end
        // Sector reads: look for the next ID field
        S_SEARCH: begin
          if (idx_rise) begin
            if (!first_sec && !op_log) begin
              state <= S_FINISH;
            end else if (idx_seen) begin
              termination_code_out <= `DTS_TC_ID;
              state                <= S_FINISH;
            end else begin
              idx_seen <= 1'b1;
            end
          end else if (rd_field_start_in && !rd_field_is_data_in) begin
            state    <= S_ID;
            byte_cnt <= 10'h000;
          end
        end
        S_ID: begin
          if (rd_byte_strobe_in) begin
            byte_cnt <= byte_cnt + 1'b1;
            case (byte_cnt[1:0])
              2'h0:    id_cyl <= rd_byte_in;
              2'h1:    id_hd  <= rd_byte_in;
              2'h2:    id_sec <= rd_byte_in;
              default: ;
            endcase
          end
          if (rd_field_end_in) begin
            if (!rd_crc_ok_in) begin
              if (can_retry) begin
                retry_left <= retry_left - 1'b1;
                state      <= S_SEARCH;
              end else begin
                termination_code_out <= `DTS_TC_ID;
                state                <= S_FINISH;
              end
            end else if (need_match && !id_match) begin
              state <= S_SEARCH;
            end else if (id_bad && opt_bypass) begin
              desired_sector_reg <= desired_sector_reg + 1'b1;
              state              <= S_SEARCH;
            end else if (id_bad) begin
              termination_code_out <= `DTS_TC_BAD;
              bad_sector_flag_out  <= op_log;
              state                <= S_FINISH;
            end else begin
              state <= S_DATA_WAIT;
            end
          end
        end
        S_DATA_WAIT: begin
          if (rd_field_start_in) begin
            state    <= rd_field_is_data_in ? S_DATA : S_SEARCH;
            byte_cnt <= 10'h000;
          end
        end
        // Data field; CRC checked even when nothing is stored
        S_DATA: begin
          if (dat_we) eng_addr <= eng_addr + 1'b1;
          if (rd_field_end_in) begin
            if (rd_crc_ok_in) begin
              sector_count_reg <= sector_count_reg - 1'b1;
              first_sec        <= 1'b0;
              idx_seen         <= 1'b0;
              retry_left       <= ~retry_count_reg;
              sec_base         <= eng_addr + AW'(dat_we);
              if (count_last) begin
                state <= S_FINISH;
              end else begin
                desired_sector_reg <= desired_sector_reg + 1'b1;
                state <= S_SEARCH;
              end
            end else if (can_retry) begin
              retry_left <= retry_left - 1'b1;
              eng_addr   <= sec_base;
              state      <= S_SEARCH;
            end else begin
              termination_code_out <= `DTS_TC_DATA;
              state                <= S_FINISH;
            end
          end
        end
        // Common ending: publish buffer address after sector reads, pulse completion
        S_FINISH: begin
          if (!op_track && !op_fmt) begin
            buffer_address_regs <= 16'(eng_addr);
          end
          read_gate_out  <= 1'b0;
          write_gate_out <= 1'b0;
          busy_out       <= 1'b0;
          cmd_done_out   <= 1'b1;
          done_sticky    <= 1'b1;
          state          <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule // dts_cmd_engine

// File: verif/dts_chk_sva.sv
// Purpose: Port-level checks of the command engine.
// Assumes: Bound to dts_cmd_engine; one clock domain.
// Notes:   Watches design outputs plus the rd_in and wr_byte_req_in inputs.
`timescale 1ns/1ps
module dts_chk_sva (
  // Clock and reset
  input wire logic               clk_in,
  input wire logic               arst_n_in,
  // Observed ports
  input wire logic               rd_in,
  input wire logic [7:0]         rd_data_out,
  input wire logic               wr_byte_req_in,
  input wire logic [7:0]         wr_byte_out,
  input wire logic               write_gate_out,
  input wire logic               read_gate_out,
  input wire dts_pkg::dts_term_t termination_code_out,
  input wire logic               bad_sector_flag_out,
  input wire logic               busy_out,
  input wire logic               cmd_done_out
);
  import dts_pkg::*;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // Completion is one pulse and ends the busy period
  a_done_pulse: assert property (cmd_done_out |=> !cmd_done_out)
    else $error("done pulse too long");
  a_done_idle: assert property (
    cmd_done_out |-> !busy_out && $past(busy_out))
    else $error("done without busy end");
  a_bad_code: assert property (
    bad_sector_flag_out && cmd_done_out |-> termination_code_out == 2'h2)
    else $error("bad flag without code 10");
  // Code only moves when a command runs or ends
  a_code_hold: assert property (
    !busy_out && $past(!busy_out) |-> $stable(termination_code_out))
    else $error("code moved while idle");
  a_wgate_busy: assert property (write_gate_out |-> busy_out)
    else $error("write gate outside command");
  a_gates_apart: assert property (
    !(write_gate_out && read_gate_out))
    else $error("both gates up");
  // Serialiser bytes change only in answer to a request
  a_wbyte_req: assert property (busy_out && $changed(wr_byte_out) |->
    $past(wr_byte_req_in) || $past(wr_byte_req_in, 2) ||
    $past(wr_byte_req_in, 3))
    else $error("byte changed without request");
  a_rd_quiet: assert property (
    !$past(rd_in) |-> rd_data_out == 8'h00)
    else $error("read data outside slot");
endmodule // dts_chk_sva

// File: verif/dts_drive_model.sv
// Purpose: Drive read channel and write serialiser model.
// Assumes: Tasks are entered just after a rising clock edge.
// Notes:   Idle byte line shows the inverse so stale bytes never match.
`timescale 1ns/1ps
module dts_drive_model #(
  parameter logic [7:0] CYL = 8'h07,
  parameter int         SB  = 8
) (
  // Clock
  input  wire logic       clk_in,
  // Write serialiser side
  input  wire logic       wgate_in,
  input  wire logic [7:0] wbyte_in,
  output logic            wreq_out,
  // Read channel side
  output logic            index_out,
  output logic            fstart_out,
  output logic            fdata_out,
  output logic            stb_out,
  output logic [7:0]      byte_out,
  output logic            fend_out,
  output logic            crc_out
);
  int         seed = 61683;
  int         cnt  = 0;
  logic [1:0] rq   = 2'b00;
  logic [7:0] sent[$];
  logic [7:0] got[$];
  // Quiet channel at time zero
  initial {index_out, fstart_out, fdata_out, stb_out, byte_out, fend_out,
           crc_out, wreq_out} = '0;
  // Request every fourth cycle; sample late so either update edge is seen
  always @(posedge clk_in) begin
    cnt <= cnt + 1;
    wreq_out <= wgate_in && cnt[1:0] == 2'b00;
    rq <= {rq[0], wreq_out};
    if (rq[1]) got.push_back(wbyte_in);
  end
  // One field; data bytes are random and logged
  task automatic field(input logic d, input int n, input logic ok,
                       input logic [31:0] id);
    logic [7:0] b;
    fstart_out <= 1'b1;
    fdata_out <= d;
    @(posedge clk_in);
    fstart_out <= 1'b0;
    for (int i = 0; i < n; i++) begin
      b = d ? 8'($random(seed)) : id[31-8*i -: 8];
      if (d) sent.push_back(b);
      stb_out <= 1'b1;
      byte_out <= b;
      @(posedge clk_in);
      stb_out <= 1'b0;
      byte_out <= ~b;
      @(posedge clk_in);
    end
    fend_out <= 1'b1;
    crc_out <= ok;
    @(posedge clk_in);
    fend_out <= 1'b0;
    crc_out <= ~ok;
    repeat (4) @(posedge clk_in);
  endtask
  task automatic sector(input logic [7:0] s, input logic bad, input logic ok);
    field(1'b0, 4, ok, {CYL, bad, 7'h00, s, 8'h02});
    field(1'b1, SB, ok, 32'h0);
  endtask
  task automatic index_pulse();
    index_out <= 1'b1;
    repeat (6) @(posedge clk_in);
    index_out <= 1'b0;
    repeat (6) @(posedge clk_in);
  endtask
endmodule // dts_drive_model

// File: verif/tb_top.sv
// Purpose: Self-checking bench of the command engine.
// Assumes: Partner model plays the drive.
// Notes:   Short sectors keep the run brief.
`timescale 1ns/1ps
`include "dts_defs.svh"
module tb_top;
  import dts_pkg::*;
  localparam int         SB  = 8;
  localparam logic [7:0] CYL = 8'h07;
  logic       clk_in, arst_n_in, wr_in, rd_in, index_pin_in, read_gate_out;
  logic       rd_field_start_in, rd_field_is_data_in, rd_byte_strobe_in;
  logic       rd_field_end_in, rd_crc_ok_in, wr_byte_req_in, write_gate_out;
  logic       bad_sector_flag_out, busy_out, cmd_done_out;
  logic [3:0] addr_in;
  logic [7:0] wdata_in, rd_data_out, rd_byte_in, wr_byte_out;
  dts_term_t  termination_code_out;
  int         num_errors = 0, checks_done = 0, dones = 0, base = 0;
  dts_cmd_engine #(.SECTOR_BYTES(SB)) dut (.clk_in, .arst_n_in, .addr_in,
    .wdata_in, .wr_in, .rd_in, .rd_data_out, .index_pin_in, .rd_field_start_in,
    .rd_field_is_data_in, .rd_byte_strobe_in, .rd_byte_in, .rd_field_end_in,
    .rd_crc_ok_in, .read_gate_out, .wr_byte_req_in, .wr_byte_out,
    .write_gate_out, .termination_code_out, .bad_sector_flag_out, .busy_out,
    .cmd_done_out);
  dts_drive_model #(.CYL(CYL), .SB(SB)) drv (.clk_in,
    .wgate_in(write_gate_out), .wbyte_in(wr_byte_out),
    .wreq_out(wr_byte_req_in), .index_out(index_pin_in),
    .fstart_out(rd_field_start_in), .fdata_out(rd_field_is_data_in),
    .stb_out(rd_byte_strobe_in), .byte_out(rd_byte_in),
    .fend_out(rd_field_end_in), .crc_out(rd_crc_ok_in));
  // 10 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  // Count completion pulses
  always @(posedge clk_in) if (cmd_done_out === 1'b1) dones <= dones + 1;
  function automatic logic [7:0] idb(input logic [7:0] s, input int i);
    logic [31:0] w;
    w = {CYL, 8'h80, s, 8'h02};
    return w[31-8*i -: 8];
  endfunction
  function automatic logic [7:0] fx(input int i);
    return (i < 16 || (i >= 20 && i < 36)) ? 8'h4E : i < 20 ? 8'h11 : 8'hE5;
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] e,
                     input string n);
    checks_done++;
    if (seen !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e, input string n);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 chk(rd_data_out, e, n);
    @(posedge clk_in);
  endtask
  task automatic prep(input logic [7:0] s, input logic [7:0] c,
                      input logic [7:0] r);
    drv.sent.delete();
    wr(`DTS_A_CYL, CYL);
    wr(`DTS_A_HEAD, 8'h00);
    wr(`DTS_A_SECT, s);
    wr(`DTS_A_COUNT, c);
    wr(`DTS_A_RETRY, r);
    wr(`DTS_A_BUFLO, 8'h00);
    wr(`DTS_A_BUFHI, 8'h00);
  endtask
  task automatic go(input logic [7:0] c);
    base = dones;
    wr(`DTS_A_CMD, c);
  endtask
  task automatic fin(input logic [7:0] st, input string n);
    for (int i = 0; i < 3000 && dones == base; i++) @(posedge clk_in);
    chk(8'(dones - base), 8'h01, "done pulses");
    rdc(`DTS_A_STATUS, st, "status");
    $display("test %s finished", n);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Cut a hang short
  initial begin
    #(100 * 40000);
    num_errors++;
    complete_run();
  end
  initial begin
    {arst_n_in, wr_in, rd_in, addr_in, wdata_in} = '0;
    repeat (5) @(posedge clk_in);
    arst_n_in <= 1'b1;
    @(posedge clk_in);
    rdc(`DTS_A_STATUS, 8'h00, "reset status");
    rdc(4'hB, 8'h00, "unmapped");
    prep(8'h03, 8'h02, 8'hFF);
    go(8'h59);
    drv.sector(8'h03, 1'b0, 1'b1);
    drv.sector(8'h09, 1'b0, 1'b1);
    fin(8'h20, "physical");
    rdc(`DTS_A_SECT, 8'h04, "sector");
    rdc(`DTS_A_COUNT, 8'h00, "count");
    rdc(`DTS_A_BUFLO, 8'h10, "buffer address");
    wr(`DTS_A_BUFLO, 8'h00);
    for (int i = 0; i < 2 * SB; i++)
      rdc(`DTS_A_DATA, drv.sent[i], "data");
    prep(8'h05, 8'h02, 8'hFF);
    go(8'h58);
    drv.sector(8'h05, 1'b0, 1'b1);
    drv.sector(8'h06, 1'b1, 1'b1);
    fin(8'h22, "physical bad");
    rdc(`DTS_A_BUFLO, 8'h00, "no transfer");
    prep(8'h05, 8'h01, 8'hFF);
    go(8'h5C);
    drv.sector(8'h05, 1'b1, 1'b1);
    fin(8'h62, "logical bad");
    prep(8'h05, 8'h02, 8'hFE);
    go(8'h5F);
    drv.sector(8'h05, 1'b1, 1'b1);
    drv.sector(8'h06, 1'b0, 1'b0);
    drv.sector(8'h06, 1'b0, 1'b1);
    drv.sector(8'h07, 1'b0, 1'b1);
    fin(8'h20, "logical bypass");
    rdc(`DTS_A_SECT, 8'h07, "sector");
    rdc(`DTS_A_COUNT, 8'h00, "count");
    for (int x = 0; x < 2; x++) begin
      prep(8'h01, 8'h01, 8'hFF);
      wr(`DTS_A_BUFLO, 8'h20);
      go({`DTS_OP_TRACK, x[0]});
      drv.index_pulse();
      drv.sector(8'h01, 1'b1, 1'b0);
      drv.index_pulse();
      fin(8'h20, "track");
      rdc(`DTS_A_BUFLO, 8'h20, "buffer address");
      wr(`DTS_A_BUFLO, 8'h20);
      for (int i = 0; i < 4 + SB * x; i++)
        rdc(`DTS_A_DATA, i < 4 ? idb(8'h01, i) : drv.sent[i-4],
            "track");
    end
    wr(`DTS_A_MODE, 8'h00);
    wr(`DTS_A_BUFLO, 8'h40);
    repeat (4) wr(`DTS_A_DATA, 8'h11);
    wr(`DTS_A_BUFLO, 8'h40);
    go(8'h60);
    drv.index_pulse();
    repeat (200) @(posedge clk_in);
    drv.index_pulse();
    fin(8'h20, "format");
    for (int i = 0; i < 36 + SB; i++) chk(drv.got[i], fx(i), "format");
    complete_run();
  end
endmodule // tb_top
bind dts_cmd_engine dts_chk_sva u_chk (.clk_in, .arst_n_in, .rd_in,
  .rd_data_out, .wr_byte_req_in, .wr_byte_out, .write_gate_out,
  .read_gate_out, .termination_code_out, .bad_sector_flag_out, .busy_out,
  .cmd_done_out);
